// >>> autoreload_pwm_timer.sv
// autoreload_pwm_timer: 12-bit auto-reload upcounter with one pulse channel,
// compare flag, polarity, shadow duty copy and an AXI4-Lite register slave.
// assumes power-mode inputs come from logic on aclk; the lite timebase
// tick arrives from outside and is synchronised here.
// Notes on behaviour
// - 12-bit upcounter counts selected clocks, restarts from reload value on overflow.
// - reset clears counter so counting starts at zero.
// - period is 4096 minus reload value counter clocks.
// - overflow loads reload, moves preloaded duty to active, drives pulse high.
// - counter equal to active duty drives pulse low until next overflow.
// - polarity bit inverts pulse; gives 0% or 100% with zero values.
// - enable bit hands pin to push-pull pulse, else pin is general I/O.
// - upper byte write suspends compare until lower byte is written.
// - with output disabled, new compare value is used at once.
// - match sets compare flag, requests interrupt when enabled.
// - zero compare value never produces a compare event.
// - overflow copies duty to shadow; pulse mode compares shadow, compare mode duty.
// - slow mode divides counter clock by 32; wait mode has no effect.
// - halt stops timer; active-halt too unless lite clock and rollover irq enabled.
// - clock field 00 off, 01 lite, 10 cpu, 11 reserved; applied at overflow, or at once while off or reserved is active.
// - overflow sets rollover flag, status read clears it, irq when enabled.
// - rollover flag clears at the next counter clock without overflow, or at a status read.
// - compare flag cleared by reading channel status register.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module autoreload_pwm_timer
  import autoreload_pwm_pkg::*;
(
  input wire logic aclk, // 20 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic lite_timebase_clock, // lite timer timebase tick, async
  input wire logic slow_mode, // cpu in slow mode
  input wire logic halt_mode, // cpu in halt
  input wire logic active_halt_mode, // cpu in active-halt
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic pulse_output_o, // pulse pin output value
  output logic pulse_output_oe_n, // pulse pin enable, low drives
  output logic pulse_alt_sel, // pin given to alternate function
  output logic rollover_irq, // rollover interrupt request
  output logic compare_irq, // compare interrupt request
  output logic rollover_wake // rollover may leave active-halt
);

  // register index from byte address
  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[IDX_LSB +: IDX_W];
  endfunction : reg_index

  // control and data state
  logic [COUNT_W-1:0] count_value_reg, count_value_next;
  logic [COUNT_W-1:0] reload_value_reg;
  logic [HIGH_W-1:0] duty_upper_byte_reg;
  logic [7:0] duty_lower_byte_reg;
  logic [COUNT_W-1:0] shadow_duty_reg;
  logic compare_locked_reg;
  logic [1:0] ck_field_reg;
  clk_sel_t sel_active_reg;
  logic rollover_flag_reg, rollover_irq_enable_reg, compare_irq_enable_reg;
  logic compare_match_flag_reg, polarity_reg, pulse_pin_enable_reg, pulse_reg;
  logic [SLOW_DIV_W-1:0] slow_div_reg;
  logic [HIGH_W-1:0] high_latch_reg;
  logic lite_s1_reg, lite_s2_reg, lite_s3_reg;

  // bus state
  logic aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // counter clock generation
  logic lite_rise, base_tick, stopped, slow_step, tick, overflow;
  logic [COUNT_W-1:0] duty_value, compare_value;
  logic compare_hit;
  assign lite_rise = lite_s2_reg & ~lite_s3_reg;
  assign base_tick = (sel_active_reg == CK_CPU) |
                     ((sel_active_reg == CK_LITE) & lite_rise);
  assign stopped = halt_mode | (active_halt_mode &
                   ~((sel_active_reg == CK_LITE) & rollover_irq_enable_reg));
  assign slow_step = clk_en & base_tick & ~stopped & slow_mode;
  assign tick = clk_en & base_tick & ~stopped &
                (~slow_mode | (slow_div_reg == SLOW_LAST));
  assign overflow = tick & (count_value_reg == COUNT_MAX);
  assign count_value_next = overflow ? reload_value_reg
                                     : count_value_reg + COUNT_ONE;

  // compare source and match
  assign duty_value = {duty_upper_byte_reg, duty_lower_byte_reg};
  assign compare_value = pulse_pin_enable_reg ? shadow_duty_reg : duty_value;
  assign compare_hit = tick & ~compare_locked_reg & (compare_value != COUNT_RESET) &
                       (count_value_next == compare_value);

  // bus decode
  logic wr_fire, rd_fire;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic wr_cs, wr_reload_hi, wr_reload_lo, wr_oc, wr_chan, wr_duty_hi, wr_duty_lo;
  logic rd_cs, rd_chan, rd_cnt_hi, rd_cnt_lo, rd_mapped, wr_mapped;
  assign wr_fire = clk_en & aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_fire = clk_en & s_axi_arvalid & s_axi_arready;
  assign wr_idx = reg_index(awaddr_reg);
  assign rd_idx = reg_index(s_axi_araddr);
  assign wr_cs = wr_fire & wlane_reg & (wr_idx == IDX_CTRL_STATUS);
  assign wr_reload_hi = wr_fire & wlane_reg & (wr_idx == IDX_RELOAD_HIGH);
  assign wr_reload_lo = wr_fire & wlane_reg & (wr_idx == IDX_RELOAD_LOW);
  assign wr_oc = wr_fire & wlane_reg & (wr_idx == IDX_OUT_CTRL);
  assign wr_chan = wr_fire & wlane_reg & (wr_idx == IDX_CHAN_STATUS);
  assign wr_duty_hi = wr_fire & wlane_reg & (wr_idx == IDX_DUTY_UPPER);
  assign wr_duty_lo = wr_fire & wlane_reg & (wr_idx == IDX_DUTY_LOWER);
  assign wr_mapped = (wr_idx == IDX_CTRL_STATUS) | (wr_idx == IDX_COUNT_HIGH) |
                     (wr_idx == IDX_COUNT_LOW) | (wr_idx == IDX_RELOAD_HIGH) |
                     (wr_idx == IDX_RELOAD_LOW) | (wr_idx == IDX_OUT_CTRL) |
                     (wr_idx == IDX_CHAN_STATUS) | (wr_idx == IDX_DUTY_UPPER) |
                     (wr_idx == IDX_DUTY_LOWER);
  assign rd_cs = rd_fire & (rd_idx == IDX_CTRL_STATUS);
  assign rd_chan = rd_fire & (rd_idx == IDX_CHAN_STATUS);
  assign rd_cnt_hi = rd_fire & (rd_idx == IDX_COUNT_HIGH);
  assign rd_cnt_lo = rd_fire & (rd_idx == IDX_COUNT_LOW);

  // read data selection
  logic [7:0] rd_byte;
  always_comb begin
    rd_mapped = 1'b1;
    rd_byte = BYTE_RESET;
    if (rd_idx == IDX_CTRL_STATUS) begin
      rd_byte[CS_CK_HI:CS_CK_LO] = ck_field_reg;
      rd_byte[CS_OVF_BIT] = rollover_flag_reg;
      rd_byte[CS_ROLLOVER_IRQ_ENABLE_BIT] = rollover_irq_enable_reg;
      rd_byte[CS_COMPARE_IRQ_ENABLE_BIT] = compare_irq_enable_reg;
    end else if (rd_idx == IDX_COUNT_HIGH) begin
      rd_byte[HIGH_W-1:0] = high_latch_reg;
    end else if (rd_idx == IDX_COUNT_LOW) begin
      rd_byte = count_value_reg[7:0];
    end else if (rd_idx == IDX_RELOAD_HIGH) begin
      rd_byte[HIGH_W-1:0] = reload_value_reg[COUNT_W-1:8];
    end else if (rd_idx == IDX_RELOAD_LOW) begin
      rd_byte = reload_value_reg[7:0];
    end else if (rd_idx == IDX_OUT_CTRL) begin
      rd_byte[OC_OE_BIT] = pulse_pin_enable_reg;
    end else if (rd_idx == IDX_CHAN_STATUS) begin
      rd_byte[CH_POL_BIT] = polarity_reg;
      rd_byte[CH_CMPF_BIT] = compare_match_flag_reg;
    end else if (rd_idx == IDX_DUTY_UPPER) begin
      rd_byte[HIGH_W-1:0] = duty_upper_byte_reg;
    end else if (rd_idx == IDX_DUTY_LOWER) begin
      rd_byte = duty_lower_byte_reg;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  // handshake outputs
  assign s_axi_awready = clk_en & ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = clk_en & ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = clk_en & ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wbyte_reg <= BYTE_RESET;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (clk_en) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        rdata_reg <= {24'h000000, rd_byte};
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ck_field_reg <= CK_OFF;
      rollover_irq_enable_reg <= 1'b0;
      compare_irq_enable_reg <= 1'b0;
      reload_value_reg <= COUNT_RESET;
      pulse_pin_enable_reg <= 1'b0;
      polarity_reg <= 1'b0;
    end else begin
      if (wr_cs) begin
        ck_field_reg <= wbyte_reg[CS_CK_HI:CS_CK_LO];
        rollover_irq_enable_reg <= wbyte_reg[CS_ROLLOVER_IRQ_ENABLE_BIT];
        compare_irq_enable_reg <= wbyte_reg[CS_COMPARE_IRQ_ENABLE_BIT];
      end
      if (wr_reload_hi) begin
        reload_value_reg[COUNT_W-1:8] <= wbyte_reg[HIGH_W-1:0];
      end
      if (wr_reload_lo) begin
        reload_value_reg[7:0] <= wbyte_reg;
      end
      if (wr_oc) begin
        pulse_pin_enable_reg <= wbyte_reg[OC_OE_BIT];
      end
      if (wr_chan) begin
        polarity_reg <= wbyte_reg[CH_POL_BIT];
      end
    end
  end

  // duty preload, compare lock and shadow copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_upper_byte_reg <= HIGH_RESET;
      duty_lower_byte_reg <= BYTE_RESET;
      compare_locked_reg <= 1'b0;
      shadow_duty_reg <= COUNT_RESET;
    end else begin
      if (wr_duty_hi) begin
        duty_upper_byte_reg <= wbyte_reg[HIGH_W-1:0];
        compare_locked_reg <= 1'b1;
      end
      if (wr_duty_lo) begin
        duty_lower_byte_reg <= wbyte_reg;
        compare_locked_reg <= 1'b0;
      end
      if (overflow) begin
        shadow_duty_reg <= duty_value;
      end
    end
  end

  // lite timebase synchroniser and edge memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lite_s1_reg <= 1'b0;
      lite_s2_reg <= 1'b0;
      lite_s3_reg <= 1'b0;
    end else if (clk_en) begin
      lite_s1_reg <= lite_timebase_clock;
      lite_s2_reg <= lite_s1_reg;
      lite_s3_reg <= lite_s2_reg;
    end
  end

  // counter, slow prescaler and clock selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_reg <= COUNT_RESET;
      slow_div_reg <= SLOW_RESET;
      sel_active_reg <= CK_OFF;
    end else begin
      if (tick) begin
        count_value_reg <= count_value_next;
        slow_div_reg <= SLOW_RESET;
      end else if (slow_step) begin
        slow_div_reg <= slow_div_reg + SLOW_ONE;
      end
      // off and reserved never overflow, so a new choice applies at once
      if (clk_en && (overflow || sel_active_reg == CK_OFF || sel_active_reg == CK_RSVD)) begin
        sel_active_reg <= clk_sel_t'(ck_field_reg);
      end
    end
  end

  // status flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rollover_flag_reg <= 1'b0;
      compare_match_flag_reg <= 1'b0;
    end else begin
      if (overflow) begin
        rollover_flag_reg <= 1'b1;
      end else if (tick || rd_cs) begin
        rollover_flag_reg <= 1'b0;
      end
      if (compare_hit) begin
        compare_match_flag_reg <= 1'b1;
      end else if (rd_chan) begin
        compare_match_flag_reg <= 1'b0;
      end
    end
  end

  // pulse generation and count high latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_reg <= 1'b0;
      high_latch_reg <= HIGH_RESET;
    end else begin
      if (compare_hit) begin
        pulse_reg <= 1'b0;
      end else if (overflow) begin
        pulse_reg <= 1'b1;
      end
      if (rd_cnt_lo) begin
        high_latch_reg <= count_value_reg[COUNT_W-1:8];
      end
    end
  end

  // pin and request outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_output_o <= 1'b0;
      pulse_output_oe_n <= 1'b1;
      pulse_alt_sel <= 1'b0;
      rollover_irq <= 1'b0;
      compare_irq <= 1'b0;
      rollover_wake <= 1'b0;
    end else if (clk_en) begin
      pulse_output_o <= pulse_reg ^ polarity_reg;
      pulse_output_oe_n <= ~pulse_pin_enable_reg;
      pulse_alt_sel <= pulse_pin_enable_reg;
      rollover_irq <= rollover_flag_reg & rollover_irq_enable_reg;
      compare_irq <= compare_match_flag_reg & compare_irq_enable_reg;
      rollover_wake <= rollover_flag_reg & rollover_irq_enable_reg &
                       (sel_active_reg == CK_LITE);
    end
  end

endmodule : autoreload_pwm_timer

// >>> autoreload_pwm_pkg.sv
// autoreload_pwm_pkg: register indices, field positions, reset values and
// clock-select codes for the 12-bit auto-reload pulse timer.
// assumes a 32-bit AXI4-Lite slave, byte address = 4 * register index.
package autoreload_pwm_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices (byte address is four times these)
  localparam logic [IDX_W-1:0] IDX_CTRL_STATUS = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_COUNT_HIGH = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_COUNT_LOW = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH = 6'h10;
  localparam logic [IDX_W-1:0] IDX_RELOAD_LOW = 6'h11;
  localparam logic [IDX_W-1:0] IDX_OUT_CTRL = 6'h12;
  localparam logic [IDX_W-1:0] IDX_CHAN_STATUS = 6'h13;
  localparam logic [IDX_W-1:0] IDX_DUTY_UPPER = 6'h17;
  localparam logic [IDX_W-1:0] IDX_DUTY_LOWER = 6'h18;
  // field positions
  localparam int CS_CK_HI = 4;
  localparam int CS_CK_LO = 3;
  localparam int CS_OVF_BIT = 2;
  localparam int CS_ROLLOVER_IRQ_ENABLE_BIT = 1;
  localparam int CS_COMPARE_IRQ_ENABLE_BIT = 0;
  localparam int CH_POL_BIT = 1;
  localparam int CH_CMPF_BIT = 0;
  localparam int OC_OE_BIT = 0;
  // counter geometry and reset values
  localparam int COUNT_W = 12;
  localparam int HIGH_W = 4;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 12'hFFF;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 12'h001;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [HIGH_W-1:0] HIGH_RESET = 4'h0;
  localparam int SLOW_DIV_W = 5;
  localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = 5'h1F;
  localparam logic [SLOW_DIV_W-1:0] SLOW_RESET = 5'h00;
  localparam logic [SLOW_DIV_W-1:0] SLOW_ONE = 5'h01;
  // counter clock selection codes
  typedef enum logic [1:0] {
    CK_OFF = 2'h0,
    CK_LITE = 2'h1,
    CK_CPU = 2'h2,
    CK_RSVD = 2'h3
  } clk_sel_t;
endpackage : autoreload_pwm_pkg

// >>> autoreload_pwm_sva.sv
// autoreload_pwm_sva: port-level checks of the auto-reload pulse timer.
// assumes one aclk domain and binding onto autoreload_pwm_timer.
`timescale 1ns/1ps
module autoreload_pwm_checker
  import autoreload_pwm_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic pulse_output_oe_n, // pin enable, low
  input wire logic pulse_alt_sel, // alt function
  input wire logic rollover_irq, // rollover request
  input wire logic compare_irq, // compare request
  input wire logic rollover_wake // wake request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers and holding
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hFC
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read ok");
  // pin, request and reset relations
  a_pin_mode: assert property (pulse_alt_sel == !pulse_output_oe_n)
    else $error("pin mode split");
  a_pin_by_write: assert property ($changed(pulse_output_oe_n) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("pin mode without write");
  a_wake_gated: assert property (rollover_wake |-> rollover_irq)
    else $error("wake without rollover");
  a_reset_quiet: assert property ($rose(aresetn) |-> pulse_output_oe_n &&
    !rollover_irq && !compare_irq) else $error("outputs not cleared");
  c_rollover: cover property (rollover_irq);
  c_compare: cover property (compare_irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : autoreload_pwm_checker

bind autoreload_pwm_timer autoreload_pwm_checker autoreload_pwm_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pulse_output_oe_n(pulse_output_oe_n),
  .pulse_alt_sel(pulse_alt_sel), .rollover_irq(rollover_irq), .compare_irq(compare_irq),
  .rollover_wake(rollover_wake));

// >>> tb_top.sv
// tb_top: self-checking bench of the auto-reload pulse timer.
// assumes a 50 ns aclk; clk_en held high; lite tick rises every 4 aclk.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import autoreload_pwm_pkg::*;
  logic aclk = 0, aresetn = 0, halt_mode = 0, active_halt_mode = 0, slow_mode = 0, lite = 0;
  logic [7:0] awaddr = 0, araddr = 0, lfsr_st = 8'h07;
  logic [31:0] wdata = 0, d, d0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pout, oe_n, alt, rirq, cirq, wake;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [7:0] mirror [64];
  int bad_count = 0, comparisons = 0, g, h, rl;
  logic [5:0] idx_tab [9] = '{IDX_CTRL_STATUS, IDX_COUNT_HIGH, IDX_COUNT_LOW, IDX_RELOAD_HIGH,
    IDX_RELOAD_LOW, IDX_OUT_CTRL, IDX_CHAN_STATUS, IDX_DUTY_UPPER, IDX_DUTY_LOWER};
  logic [7:0] mask_tab [9] = '{8'h1B, 8'h00, 8'h00, 8'h0F, 8'hFF, 8'h01, 8'h02, 8'h0F, 8'hFF};
  autoreload_pwm_timer autoreload_pwm_timer_inst (.aclk(aclk), .aresetn(aresetn),
    .clk_en(1'b1), .lite_timebase_clock(lite), .slow_mode(slow_mode), .halt_mode(halt_mode),
    .active_halt_mode(active_halt_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pulse_output_o(pout), .pulse_output_oe_n(oe_n), .pulse_alt_sel(alt),
    .rollover_irq(rirq), .compare_irq(cirq), .rollover_wake(wake));
  // clock
  initial forever #25 aclk = ~aclk;
  // lite timebase: one rising edge every 4 aclk
  initial forever begin repeat (2) @(posedge aclk); lite <= ~lite; end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // bus write: aw and w offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] rs);
    logic ad, wd, ha, hw, hb;
    ad = 0;
    wd = 0;
    hb = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge aclk);
      if (ha) begin awvalid <= 1'b0; ad = 1; end
      if (hw) begin wvalid <= 1'b0; wd = 1; end
    end
    while (!hb) begin
      @(negedge aclk);
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask : wr
  // bus read
  task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr;
    ha = 0;
    hr = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ha) begin
      @(negedge aclk);
      ha = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    while (!hr) begin
      @(negedge aclk);
      hr = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask : rd
  // mapped write, mirror keeps the readable bits
  task automatic wm(input logic [5:0] idx, input logic [7:0] v, input logic [7:0] m);
    logic [1:0] rs;
    wr(idx, v, rs);
    `CHK(rs, RESP_OKAY)
    mirror[idx] = v & m;
  endtask : wm
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // rollover period and request width in aclk cycles
  task automatic irq_gap(output int gp, output int hi);
    gp = 0;
    hi = 0;
    while (rirq === 1'b1) @(negedge aclk);
    while (rirq !== 1'b1) @(negedge aclk);
    while (rirq === 1'b1) begin hi++; gp++; @(negedge aclk); end
    while (rirq !== 1'b1) begin gp++; @(negedge aclk); end
  endtask : irq_gap
  // high cycles of the pin over one 16-cycle period
  task automatic pulse_hi(output int hc);
    hc = 0;
    repeat (16) begin @(negedge aclk); if (pout === 1'b1) hc++; end
  endtask : pulse_hi
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    $display("mismatch at %0t watchdog expired", $time);
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(idx_tab[i], d, r);
      `CHK(d, 32'h0)
    end
    for (int i = 0; i < 9; i++) begin
      lfsr_st = lfsr_next(lfsr_st);
      wm(idx_tab[i], (i == 0) ? 8'h03 : lfsr_st, mask_tab[i]);
    end
    for (int i = 0; i < 9; i++) begin
      rd(idx_tab[i], d, r);
      `CHK(d, {24'h0, mirror[idx_tab[i]]})
    end
    wr(6'h3F, 8'h01, r);
    `CHK(r, RESP_SLVERR)
    rd(6'h3F, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
    for (int i = 0; i < 9; i++) wm(idx_tab[i], 8'h00, mask_tab[i]);
    $display("test registers done");
    rl = 'hFF0;
    wm(IDX_RELOAD_HIGH, 8'h0F, 8'h0F);
    wm(IDX_RELOAD_LOW, 8'hF0, 8'hFF);
    wm(IDX_DUTY_UPPER, 8'h0F, 8'h0F);
    wm(IDX_DUTY_LOWER, 8'hF4, 8'hFF);
    wm(IDX_OUT_CTRL, 8'h01, 8'h01);
    wm(IDX_CTRL_STATUS, 8'h12, 8'h1B);
    irq_gap(g, h);
    `CHK(g, 4096 - rl)
    `CHK(h, 1)
    cyc(40);
    @(negedge aclk);
    `CHK(oe_n, 1'b0)
    `CHK(alt, 1'b1)
    pulse_hi(h);
    `CHK(h, 'hFF4 - rl)
    wm(IDX_CHAN_STATUS, 8'h02, 8'h02);
    cyc(4);
    pulse_hi(h);
    `CHK(h, 16 - ('hFF4 - rl))
    @(posedge rirq);
    wm(IDX_DUTY_UPPER, 8'h00, 8'h0F);
    wm(IDX_DUTY_LOWER, 8'h00, 8'hFF);
    cyc(40);
    pulse_hi(h);
    `CHK(h, 0)
    wm(IDX_CHAN_STATUS, 8'h00, 8'h02);
    cyc(4);
    pulse_hi(h);
    `CHK(h, 16)
    @(posedge aclk);
    slow_mode <= 1'b1;
    irq_gap(g, h);
    irq_gap(g, h);
    `CHK(g, 32 * (4096 - rl))
    `CHK(h, 32)
    @(posedge aclk);
    slow_mode <= 1'b0;
    $display("test pulse done");
    wm(IDX_OUT_CTRL, 8'h00, 8'h01);
    rd(IDX_CHAN_STATUS, d, r);
    `CHK(d, 32'h1)
    wm(IDX_CTRL_STATUS, 8'h11, 8'h1B);
    wm(IDX_DUTY_UPPER, 8'h0F, 8'h0F);
    wm(IDX_DUTY_LOWER, 8'hF8, 8'hFF);
    cyc(40);
    halt_mode <= 1'b1;
    cyc(5);
    @(negedge aclk);
    `CHK(oe_n, 1'b1)
    `CHK(alt, 1'b0)
    `CHK(cirq, 1'b1)
    rd(IDX_CHAN_STATUS, d, r);
    `CHK(d, 32'h1)
    rd(IDX_CHAN_STATUS, d, r);
    `CHK(d, 32'h0)
    @(negedge aclk);
    `CHK(cirq, 1'b0)
    rd(IDX_COUNT_LOW, d0, r);
    rd(IDX_COUNT_LOW, d, r);
    `CHK(d, d0)
    rd(IDX_COUNT_HIGH, d, r);
    `CHK(d, 32'h0F)
    wm(IDX_DUTY_UPPER, 8'h0F, 8'h0F);
    halt_mode <= 1'b0;
    cyc(40);
    halt_mode <= 1'b1;
    cyc(3);
    rd(IDX_CHAN_STATUS, d, r);
    `CHK(d, 32'h0)
    wm(IDX_DUTY_LOWER, 8'hF8, 8'hFF);
    halt_mode <= 1'b0;
    cyc(40);
    halt_mode <= 1'b1;
    cyc(3);
    rd(IDX_CHAN_STATUS, d, r);
    `CHK(d, 32'h1)
    halt_mode <= 1'b0;
    active_halt_mode <= 1'b1;
    cyc(3);
    rd(IDX_COUNT_LOW, d0, r);
    cyc(20);
    rd(IDX_COUNT_LOW, d, r);
    `CHK(d, d0)
    active_halt_mode <= 1'b0;
    wm(IDX_CTRL_STATUS, 8'h0A, 8'h1B);
    irq_gap(g, h);
    @(posedge aclk);
    active_halt_mode <= 1'b1;
    irq_gap(g, h);
    `CHK(g, 4 * (4096 - rl))
    `CHK(wake, 1'b1)
    $display("test compare done");
    wrap_up();
  end
endmodule : tb_top
